// ---- src/stpg_defs.svh ----
// constants for the spanning tree port state gate: offsets, fields, resets
// assumes inclusion by stpg_gate only; no processes here
`ifndef STPG_DEFS_SVH
`define STPG_DEFS_SVH

`define STPG_IDX_P1_CTRL 6'h12
`define STPG_IDX_P2_CTRL 6'h22
`define STPG_IDX_STATUS 6'h01
`define STPG_IDX_DROPS 6'h02

`define STPG_BIT_LRNDIS 0
`define STPG_BIT_RXEN 1
`define STPG_BIT_TXEN 2
`define STPG_CTRL_RST 3'h6
`define STPG_CTRL_CLOSED 3'h1
`define STPG_CTRL_LEARN 3'h0
`define STPG_CTRL_FWD 3'h6

`define STPG_SRC_P1 2'h1
`define STPG_SRC_P2 2'h2
`define STPG_SRC_P3 2'h3

`define STPG_DESC_W 9
`define STPG_FIFO_DEPTH 4
`define STPG_ST_P2_LSB 8

`endif

// ---- src/stpg_pkg.sv ----
// types for the spanning tree port state gate
// assumes nothing beyond the defs header
package stpg_pkg;
  typedef enum logic [1:0] {
    STPG_CLOSED,
    STPG_LEARNING,
    STPG_FORWARDING,
    STPG_MIXED
  } stpg_state_t;
endpackage : stpg_pkg

// ---- src/stpg_fifo.sv ----
// small flip-flop fifo with valid and ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module stpg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic rdy_reg, rdy_next;
  logic push, pop;

  assign push = in_valid && rdy_reg;
  assign pop = out_valid && out_ready;
  assign in_ready = rdy_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (push) begin
      mem_next[wr_reg] = in_data;
    end
    wr_next = push ? ((wr_reg == LAST) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? ((rd_reg == LAST) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
    rdy_next = (cnt_next != FULL);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
      mem_reg <= mem_next;
    end
  end
endmodule : stpg_fifo
`default_nettype wire

// ---- src/stpg_gate.sv ----
// spanning tree port state gate: per-packet forward mask and learn decision
// assumes a lookup stage feeding descriptors and an avalon-mm master on the registers
`timescale 1ns/10ps
`default_nettype none
`include "stpg_defs.svh"
module stpg_gate (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_src,
  input wire logic [2:0] in_dmask,
  input wire logic in_ovr,
  input wire logic [1:0] in_tag,
  input wire logic in_learn,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_src,
  output logic [2:0] out_mask,
  output logic out_learn
);
  // per-port settings
  logic [2:0] cfg_reg [2];
  logic [2:0] cfg_next [2];
  logic [1:0] tx_en, rx_en, lrn_dis;
  stpg_pkg::stpg_state_t st [2];

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      assign tx_en[gp] = cfg_reg[gp][`STPG_BIT_TXEN];
      assign rx_en[gp] = cfg_reg[gp][`STPG_BIT_RXEN];
      assign lrn_dis[gp] = cfg_reg[gp][`STPG_BIT_LRNDIS];
      // disable, blocking and listening collapse to one code
      always_comb begin
        case (cfg_reg[gp])
          `STPG_CTRL_CLOSED: st[gp] = stpg_pkg::STPG_CLOSED;
          `STPG_CTRL_LEARN: st[gp] = stpg_pkg::STPG_LEARNING;
          `STPG_CTRL_FWD: st[gp] = stpg_pkg::STPG_FORWARDING;
          default: st[gp] = stpg_pkg::STPG_MIXED;
        endcase
      end
    end
  endgenerate

  // descriptor fifo
  logic f_valid, f_ready;
  logic [`STPG_DESC_W-1:0] f_data;

  stpg_fifo #(
    .WIDTH(`STPG_DESC_W),
    .DEPTH(`STPG_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({in_src, in_dmask, in_ovr, in_tag, in_learn}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  logic [1:0] hd_src, hd_tag;
  logic [2:0] hd_dmask;
  logic hd_ovr, hd_lrn, hd_net, hd_idx, load;
  logic [2:0] dec_mask, src_bit;
  logic dec_learn;

  assign hd_src = f_data[8:7];
  assign hd_dmask = f_data[6:4];
  assign hd_ovr = f_data[3];
  assign hd_tag = f_data[2:1];
  assign hd_lrn = f_data[0];
  assign hd_net = (hd_src == `STPG_SRC_P1) || (hd_src == `STPG_SRC_P2);
  assign hd_idx = (hd_src == `STPG_SRC_P2);
  assign f_ready = !out_valid || out_ready;
  assign load = f_valid && f_ready;

  // forwarding decision
  always_comb begin
    src_bit = 3'h0;
    dec_mask = 3'h0;
    dec_learn = 1'b0;
    if (hd_src == `STPG_SRC_P3) begin
      if (hd_tag != 2'h0) begin
        dec_mask = {1'b0, hd_tag};
      end else begin
        dec_mask = {1'b0, hd_dmask[1:0]};
      end
      dec_learn = hd_lrn;
    end else if (hd_net) begin
      src_bit = hd_idx ? 3'h2 : 3'h1;
      if (rx_en[hd_idx]) begin
        dec_mask = hd_dmask & {1'b1, tx_en} & ~src_bit;
      end else if (hd_ovr) begin
        dec_mask = hd_dmask & 3'h4;
      end
      dec_learn = hd_lrn && !lrn_dis[hd_idx];
    end
  end

  // output stage
  logic out_valid_reg, out_valid_next, out_learn_reg, out_learn_next;
  logic [1:0] out_src_reg, out_src_next;
  logic [2:0] out_mask_reg, out_mask_next;
  logic [15:0] drops_reg, drops_next;

  always_comb begin
    out_valid_next = out_valid_reg;
    out_src_next = out_src_reg;
    out_mask_next = out_mask_reg;
    out_learn_next = out_learn_reg;
    drops_next = drops_reg;
    if (out_valid_reg && out_ready) begin
      out_valid_next = 1'b0;
    end
    if (load) begin
      out_valid_next = 1'b1;
      out_src_next = hd_src;
      out_mask_next = dec_mask;
      out_learn_next = dec_learn;
      if (dec_mask == 3'h0) begin
        drops_next = drops_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
      out_src_reg <= 2'h0;
      out_mask_reg <= 3'h0;
      out_learn_reg <= 1'b0;
      drops_reg <= 16'h0000;
    end else begin
      out_valid_reg <= out_valid_next;
      out_src_reg <= out_src_next;
      out_mask_reg <= out_mask_next;
      out_learn_reg <= out_learn_next;
      drops_reg <= drops_next;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_src = out_src_reg;
  assign out_mask = out_mask_reg;
  assign out_learn = out_learn_reg;

  // avalon slave: one wait cycle, access at the edge waitrequest is low
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [5:0] idx;
  logic go_wr;

  assign idx = avs_address[7:2];
  assign go_wr = avs_write && !wait_reg && avs_byteenable[0];

  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    cfg_next[0] = cfg_reg[0];
    cfg_next[1] = cfg_reg[1];
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = 32'h0000_0000;
      case (idx)
        `STPG_IDX_P1_CTRL: rdata_next[2:0] = cfg_reg[0];
        `STPG_IDX_P2_CTRL: rdata_next[2:0] = cfg_reg[1];
        `STPG_IDX_STATUS: begin
          rdata_next[1:0] = st[0];
          rdata_next[`STPG_ST_P2_LSB+1:`STPG_ST_P2_LSB] = st[1];
        end
        `STPG_IDX_DROPS: rdata_next[15:0] = drops_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    if (go_wr && idx == `STPG_IDX_P1_CTRL) begin
      cfg_next[0] = avs_writedata[2:0];
    end
    if (go_wr && idx == `STPG_IDX_P2_CTRL) begin
      cfg_next[1] = avs_writedata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      cfg_reg[0] <= `STPG_CTRL_RST;
      cfg_reg[1] <= `STPG_CTRL_RST;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      cfg_reg[0] <= cfg_next[0];
      cfg_reg[1] <= cfg_next[1];
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_take_net_closed_rx;
    load && hd_net && !rx_en[hd_idx];
  endsequence

  sequence s_bus_answer;
    (avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  AST_RX_CLOSED_ONLY_OVR: assert property (
    s_take_net_closed_rx |=> out_valid && out_mask[1:0] == 2'h0 && out_mask[2] == $past(hd_ovr && hd_dmask[2]))
    else $error("closed port leaked traffic");

  AST_OVR_TO_CPU: assert property (
    s_take_net_closed_rx ##0 (hd_ovr && hd_dmask[2]) |=> out_mask == 3'h4)
    else $error("override match not sent to processor");

  AST_TAG_BYPASS: assert property (
    load && hd_src == `STPG_SRC_P3 && hd_tag != 2'h0 |=> out_mask == {1'b0, $past(hd_tag)})
    else $error("special tag mask not honoured");

  AST_CPU_TO_PORT: assert property (
    load && hd_src == `STPG_SRC_P3 && hd_tag == 2'h0 |=> out_mask == {1'b0, $past(hd_dmask[1:0])})
    else $error("processor packet gated by port state");

  AST_NO_LEARN: assert property (
    load && hd_net && lrn_dis[hd_idx] |=> !out_learn)
    else $error("learning on a learn disabled port");

  AST_LEARN_STATE: assert property (
    load && hd_net && cfg_reg[hd_idx] == `STPG_CTRL_LEARN
      |=> out_learn == $past(hd_lrn) && out_mask[1:0] == 2'h0)
    else $error("learning state wrong");

  AST_FWD_STATE: assert property (
    load && hd_net && cfg_reg[hd_idx] == `STPG_CTRL_FWD
      |=> out_mask == ($past(hd_dmask) & {1'b1, $past(tx_en)} & ~$past(src_bit)) && out_learn == $past(hd_lrn))
    else $error("forwarding state wrong");

  AST_CLOSED_CODE: assert property (
    cfg_reg[0] == `STPG_CTRL_CLOSED |-> st[0] == stpg_pkg::STPG_CLOSED)
    else $error("closed states not merged");

  AST_CFG_WRITE: assert property (
    avs_write && !avs_waitrequest && avs_byteenable[0] && idx == `STPG_IDX_P2_CTRL
      |=> cfg_reg[1] == $past(avs_writedata[2:0]))
    else $error("port 2 setting not stored");

  AST_BUS_ONE_WAIT: assert property (
    s_bus_answer |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");

  AST_OUT_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_mask) && $stable(out_src))
    else $error("output dropped under back-pressure");

  AST_P3_ONLY: assert property (
    load && !hd_net && hd_src != `STPG_SRC_P3 |=> out_mask == 3'h0)
    else $error("unknown source forwarded");

  AST_CFG_WRITE_P1: assert property (
    avs_write && !avs_waitrequest && avs_byteenable[0] && idx == `STPG_IDX_P1_CTRL
      |=> cfg_reg[0] == $past(avs_writedata[2:0]))
    else $error("port 1 setting not stored");

  AST_BE_GUARD: assert property (
    avs_write && !avs_byteenable[0] |=> cfg_reg[0] == $past(cfg_reg[0]) && cfg_reg[1] == $past(cfg_reg[1]))
    else $error("setting changed without byte enable");

  AST_READ_CFG: assert property (
    avs_read && avs_waitrequest && idx == `STPG_IDX_P2_CTRL |=> avs_readdata == {29'h0, $past(cfg_reg[1])})
    else $error("port 2 setting read wrong");

  AST_DROP_COUNT: assert property (
    load && dec_mask == 3'h0 |=> drops_reg == $past(drops_reg) + 16'h0001)
    else $error("dropped decision not counted");

  AST_SRC_KEPT: assert property (
    load |=> out_valid && out_src == $past(hd_src))
    else $error("source port lost");

  AST_NO_ECHO: assert property (
    load && hd_src == `STPG_SRC_P3 |=> !out_mask[2])
    else $error("processor packet sent back to processor");

  AST_NO_SELF: assert property (
    load && hd_net |=> (out_mask & $past(src_bit)) == 3'h0)
    else $error("packet sent back to its own port");

  AST_CLOSED_CODE_P2: assert property (
    cfg_reg[1] == `STPG_CTRL_CLOSED |-> st[1] == stpg_pkg::STPG_CLOSED)
    else $error("port 2 closed states not merged");
endmodule : stpg_gate
`default_nettype wire

// ---- dv/stpg_sink.sv ----
// far-side sink model: takes the gated decisions, stalls when asked
// assumes the bench drives hold by non-blocking assignment at the rising edge
`timescale 1ns/10ps
`default_nettype none
module stpg_sink (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hold,
  input wire logic out_valid,
  output logic out_ready
);
  logic ready_reg;
  // ready only out of reset and while not stalled, one cycle after hold moves
  always_ff @(posedge ref_clk) begin
    ready_reg <= !srst && !hold;
  end
  assign out_ready = ready_reg;
endmodule : stpg_sink
`default_nettype wire

// ---- dv/stpg_gate_tb.sv ----
// self-checking bench for the spanning tree port state gate
// assumes stpg_gate with its fifo inside, and the stpg_sink model on the decision side
`timescale 1ns/10ps
`default_nettype none
module spanning_tree_port_state_gate_tb_top;
  typedef struct packed {
    logic [2:0] cfg1;
    logic [2:0] cfg2;
    logic [1:0] src;
    logic [2:0] dmask;
    logic ovr;
    logic [1:0] tag;
    logic lrn;
    logic [2:0] mask;
    logic elrn;
  } stpg_row_t;
  // cfg1 cfg2 src dmask ovr tag lrn : mask learn
  stpg_row_t rows [11] = '{
    '{3'h6, 3'h6, 2'h1, 3'h7, 1'h0, 2'h0, 1'h1, 3'h6, 1'h1},
    '{3'h1, 3'h6, 2'h1, 3'h6, 1'h0, 2'h0, 1'h1, 3'h0, 1'h0},
    '{3'h1, 3'h6, 2'h1, 3'h4, 1'h1, 2'h0, 1'h1, 3'h4, 1'h0},
    '{3'h0, 3'h6, 2'h1, 3'h6, 1'h1, 2'h0, 1'h1, 3'h4, 1'h1},
    '{3'h0, 3'h6, 2'h2, 3'h1, 1'h0, 2'h0, 1'h1, 3'h0, 1'h1},
    '{3'h1, 3'h6, 2'h3, 3'h1, 1'h0, 2'h0, 1'h1, 3'h1, 1'h1},
    '{3'h1, 3'h1, 2'h3, 3'h0, 1'h0, 2'h3, 1'h0, 3'h3, 1'h0},
    '{3'h6, 3'h6, 2'h3, 3'h7, 1'h0, 2'h0, 1'h1, 3'h3, 1'h1},
    '{3'h6, 3'h6, 2'h0, 3'h7, 1'h1, 2'h0, 1'h1, 3'h0, 1'h0},
    '{3'h6, 3'h1, 2'h2, 3'h5, 1'h1, 2'h0, 1'h1, 3'h4, 1'h0},
    '{3'h7, 3'h1, 2'h1, 3'h6, 1'h0, 2'h0, 1'h1, 3'h4, 1'h0}
  };
  logic ref_clk;
  logic srst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic in_valid;
  logic in_ready;
  logic [1:0] in_src;
  logic [2:0] in_dmask;
  logic in_ovr;
  logic [1:0] in_tag;
  logic in_learn;
  logic out_valid;
  logic out_ready;
  logic [1:0] out_src;
  logic [2:0] out_mask;
  logic out_learn;
  logic hold;
  logic [31:0] rd;
  logic [5:0] outq [$];
  int mismatches;
  int compares;
  int drops;
  int acc;
  stpg_gate stpg_gate_inst (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready),
    .in_src(in_src), .in_dmask(in_dmask), .in_ovr(in_ovr), .in_tag(in_tag), .in_learn(in_learn),
    .out_valid(out_valid), .out_ready(out_ready), .out_src(out_src), .out_mask(out_mask), .out_learn(out_learn));
  stpg_sink stpg_sink_inst (.ref_clk(ref_clk), .srst(srst), .hold(hold), .out_valid(out_valid),
    .out_ready(out_ready));
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) outq.push_back({out_src, out_mask, out_learn});
  end
  function automatic logic [1:0] code(input logic [2:0] c);
    if (c == 3'h1) return 2'h0;
    if (c == 3'h0) return 2'h1;
    if (c == 3'h6) return 2'h2;
    return 2'h3;
  endfunction : code
  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task automatic fail_to(input string name);
    mismatches++;
    $display("BAD %s expected answer seen timeout", name);
    stop_test();
  endtask : fail_to
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] be);
    int n;
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) fail_to("waitrequest");
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic send(input logic [1:0] s, input logic [2:0] dm, input logic o, input logic [1:0] t, input logic l);
    int n;
    in_valid <= 1'b1;
    in_src <= s;
    in_dmask <= dm;
    in_ovr <= o;
    in_tag <= t;
    in_learn <= l;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) fail_to("in_ready");
    end while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : send
  task automatic wait_out(input int cnt);
    int n;
    n = 0;
    while (outq.size() < cnt) begin
      @(negedge ref_clk);
      n++;
      if (n > 40) fail_to("out_valid");
    end
    @(posedge ref_clk);
  endtask : wait_out
  initial begin
    {mismatches, compares, drops, acc} = '0;
    {srst, hold, avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = {2'h2, 46'h0};
    {in_valid, in_src, in_dmask, in_ovr, in_tag, in_learn} = 10'h0;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 8'h48, 32'h0, 4'hF);
    chk("p1 cfg reset", 32'h6, rd);
    bus(1'b0, 8'h88, 32'h0, 4'hF);
    chk("p2 cfg reset", 32'h6, rd);
    bus(1'b0, 8'h04, 32'h0, 4'hF);
    chk("status reset", 32'h202, rd);
    bus(1'b1, 8'h0C, 32'h7, 4'hF);
    bus(1'b0, 8'h0C, 32'h0, 4'hF);
    chk("unmapped", 32'h0, rd);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, 8'h48, {29'h0, rows[i].cfg1}, 4'h1);
      bus(1'b1, 8'h88, {29'h0, rows[i].cfg2}, 4'h1);
      bus(1'b0, 8'h04, 32'h0, 4'hF);
      chk("status", {22'h0, code(rows[i].cfg2), 6'h0, code(rows[i].cfg1)}, rd);
      outq.delete();
      send(rows[i].src, rows[i].dmask, rows[i].ovr, rows[i].tag, rows[i].lrn);
      wait_out(1);
      chk("out_src", {30'h0, rows[i].src}, {30'h0, outq[0][5:4]});
      chk("out_mask", {29'h0, rows[i].mask}, {29'h0, outq[0][3:1]});
      chk("out_learn", {31'h0, rows[i].elrn}, {31'h0, outq[0][0]});
      if (rows[i].mask == 3'h0) drops++;
    end
    $display("test table done");
    bus(1'b0, 8'h08, 32'h0, 4'hF);
    chk("drop count", drops, rd);
    bus(1'b1, 8'h48, 32'h6, 4'h1);
    bus(1'b1, 8'h48, 32'h1, 4'hE);
    bus(1'b0, 8'h48, 32'h0, 4'hF);
    chk("byteenable guard", 32'h6, rd);
    $display("test registers done");
    outq.delete();
    hold <= 1'b1;
    in_valid <= 1'b1;
    {in_src, in_dmask, in_ovr, in_tag, in_learn} <= {2'h1, 3'h4, 4'h0};
    repeat (10) begin
      @(posedge ref_clk);
      if (in_ready === 1'b1) acc++;
    end
    in_valid <= 1'b0;
    chk("accepted under stall", 32'h5, acc);
    hold <= 1'b0;
    wait_out(5);
    foreach (outq[i]) chk("drained", 32'h18, {26'h0, outq[i]});
    $display("test stall done");
    bus(1'b1, 8'h88, 32'h1, 4'h1);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, 8'h88, 32'h0, 4'hF);
    chk("p2 cfg after reset", 32'h6, rd);
    $display("test second reset done");
    stop_test();
  end
endmodule : spanning_tree_port_state_gate_tb_top
`default_nettype wire
